// ---- core/typeb_req_map.vh ----
// Purpose: Constants for the Type B request and wake-up responder
// Assumes: Byte-wide command and answer streams
// Notes: Definitions only
`ifndef TYPEB_REQ_MAP_VH
`define TYPEB_REQ_MAP_VH
// ---------------------------------------------
// Command and answer codes
// ---------------------------------------------
`define CMD_REQ_CODE 8'h05
`define ANS_CODE 8'h50
`define PARAM_WAKE_BIT 3
`define PARAM_FORM_MSB 4
`define PARAM_FORM_LSB 0
`define PARAM_REQ_FORM 5'h00
`define PARAM_WAKE_FORM 5'h08
// ---------------------------------------------
// Protocol information
// ---------------------------------------------
`define PROTO1_MULTI 8'hB3
`define PROTO1_SLOW 8'h80
`define PROTO2_BYTE 8'h81
`define PROTO3_LOW 4'h0
// ---------------------------------------------
// Frame lengths and CRC_B
// ---------------------------------------------
`define CMD_LEN 3'h5
`define ANS_LEN 4'hE
`define ANS_BODY_LEN 4'hC
`define CRC_INIT 16'h6363
`define CRC_POLY_REV 16'h8408
`define CRC_RESIDUE 16'hF0B8
`define NIB_ZERO 4'h0
`define BYTE_ZERO 8'h00
`endif

// ---- core/crc_b_unit.v ----
// Purpose: CRC_B byte update, serial over one byte per clock
// Assumes: Reflected polynomial, preset value on clear
// Notes: Check value is the register before complement
`timescale 1ns/1ps
`include "typeb_req_map.vh"
module crc_b_unit (
    input wire core_clk_i,
    input wire arst_n_i,
    input wire clear_i,
    input wire step_i,
    input wire [7:0] data_i,
    output wire [15:0] crc_o
);
    reg [15:0] crc_reg;
    reg [15:0] crc_next;
    integer k;
    // ---------------------------------------------
    // Byte update
    // ---------------------------------------------
    always @* begin
        crc_next = crc_reg ^ {8'h00, data_i};
        for (k = 0; k < 8; k = k + 1) begin
            if (crc_next[0]) begin
                crc_next = (crc_next >> 1) ^ `CRC_POLY_REV;
            end else begin
                crc_next = crc_next >> 1;
            end
        end
    end
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            crc_reg <= `CRC_INIT;
        end else if (clear_i) begin
            crc_reg <= `CRC_INIT;
        end else if (step_i) begin
            crc_reg <= crc_next;
        end
    end
    assign crc_o = crc_reg;
endmodule // crc_b_unit

// ---- core/typeb_request_wakeup_responder.v ----
// Purpose: Decode request/wake-up frames and send the answer frame
// Assumes: Command bytes arrive with a frame end strobe; answer drained by ready
// Notes: Attach, block protocol and identifier source live elsewhere
`timescale 1ns/1ps
`include "typeb_req_map.vh"
// Operation
// - Request form answered in idle state
// - Wake-up answered in halt and idle
// - Low nibble family must match stored low
// - Zero family byte matches any stored family
// - High nibble family must match stored high
// - Other family bytes need exact match
// - Parameter bits 7-5 are ignored
// - Any slot code treated as one slot
// - Answer starts with code 0x50
// - Application data bytes always zero
// - Multi-rate byte when fast rate clear and Type B rate set
// - Fast rate set gives 0x80
// - Frame size nibble 1000b, 256 bytes
// - Protocol type nibble 0001b
// - Waiting time integer in high nibble
// - Application coding bits 00b
// - Frame option bits 00b
module typeb_request_wakeup_responder (
    input wire core_clk_i,
    input wire arst_n_i,
    input wire rx_valid_i,
    input wire [7:0] rx_data_i,
    input wire rx_end_i,
    input wire halted_i,
    input wire active_i,
    input wire [7:0] family_setting_i,
    input wire [31:0] identifier_i,
    input wire fast_rate_select_i,
    input wire typeb_rate_select_i,
    input wire [3:0] wait_int_i,
    input wire tx_ready_i,
    output wire tx_valid_o,
    output reg [7:0] tx_data_o,
    output wire tx_last_o,
    output reg answered_o,
    output reg wake_seen_o,
    output wire busy_o
);
    // ---------------------------------------------
    // States
    // ---------------------------------------------
    localparam [2:0] ST_RX = 3'b001;
    localparam [2:0] ST_TX = 3'b010;
    localparam [2:0] ST_CRC = 3'b100;

    reg [2:0] state_reg;
    reg [2:0] rx_cnt_reg;
    reg [7:0] cmd_reg;
    reg [7:0] fam_reg;
    reg [7:0] par_reg;
    reg [3:0] tx_idx_reg;
    reg ovf_reg;
    wire [15:0] crc_val;
    wire crc_clear;
    wire crc_step;
    wire [7:0] crc_byte;
    wire frame_ok;
    wire form_ok;
    wire is_wake;
    wire state_ok;
    wire fam_ok;
    wire accept;
    reg [7:0] body_byte;
    wire tx_fire;

    // ---------------------------------------------
    // Family match
    // ---------------------------------------------
    function fam_match;
        input [7:0] req;
        input [7:0] own;
        begin
            if (req == `BYTE_ZERO) begin
                fam_match = 1'b1;
            end else if (req[7:4] == `NIB_ZERO) begin
                fam_match = (req[3:0] == own[3:0]);
            end else if (req[3:0] == `NIB_ZERO) begin
                fam_match = (req[7:4] == own[7:4]);
            end else begin
                fam_match = (req == own);
            end
        end
    endfunction

    // ---------------------------------------------
    // Command decode
    // ---------------------------------------------
    // Bits 7-5 and slot code never enter the decision
    assign is_wake = par_reg[`PARAM_WAKE_BIT];
    assign form_ok = (par_reg[`PARAM_FORM_MSB:`PARAM_FORM_LSB] & ~5'h07 & ~5'h08) == 5'h00
        && (cmd_reg == `CMD_REQ_CODE);
    // Request only from idle; wake-up from idle or halt
    assign state_ok = !active_i && (is_wake || !halted_i);
    assign fam_ok = fam_match(fam_reg, family_setting_i);
    assign frame_ok = (rx_cnt_reg == `CMD_LEN) && !ovf_reg
        && (crc_val == `CRC_RESIDUE);
    assign accept = (state_reg == ST_RX) && rx_end_i && frame_ok
        && form_ok && state_ok && fam_ok;

    // ---------------------------------------------
    // Answer body
    // ---------------------------------------------
    always @* begin
        case (tx_idx_reg)
            4'h0: body_byte = `ANS_CODE;
            4'h1: body_byte = identifier_i[7:0];
            4'h2: body_byte = identifier_i[15:8];
            4'h3: body_byte = identifier_i[23:16];
            4'h4: body_byte = identifier_i[31:24];
            4'h5, 4'h6, 4'h7, 4'h8: body_byte = `BYTE_ZERO;
            4'h9: begin
                if (fast_rate_select_i || !typeb_rate_select_i) begin
                    body_byte = `PROTO1_SLOW;
                end else begin
                    body_byte = `PROTO1_MULTI;
                end
            end
            4'hA: body_byte = `PROTO2_BYTE;
            4'hB: body_byte = {wait_int_i, `PROTO3_LOW};
            default: body_byte = `BYTE_ZERO;
        endcase
    end

    // Shared CRC: command bytes in receive, answer bytes in transmit
    // Preset again after the answer, else the next command starts off a stale check
    assign crc_clear = ((state_reg == ST_RX) && rx_end_i)
        || ((state_reg == ST_CRC) && tx_fire && tx_last_o);
    assign crc_step = ((state_reg == ST_RX) && rx_valid_i && !rx_end_i)
        || ((state_reg == ST_TX) && tx_fire);
    assign crc_byte = (state_reg == ST_RX) ? rx_data_i : body_byte;

    crc_b_unit u_crc (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .clear_i(crc_clear),
        .step_i(crc_step),
        .data_i(crc_byte),
        .crc_o(crc_val)
    );

    assign tx_valid_o = (state_reg != ST_RX);
    assign tx_fire = tx_valid_o && tx_ready_i;
    assign tx_last_o = (state_reg == ST_CRC) && (tx_idx_reg == `ANS_LEN - 4'h1);
    assign busy_o = (state_reg != ST_RX);

    always @* begin
        if (state_reg == ST_CRC) begin
            // Check holds still here: no step outside receive and body
            tx_data_o = (tx_idx_reg == `ANS_BODY_LEN) ? ~crc_val[7:0]
                : ~crc_val[15:8];
        end else begin
            tx_data_o = body_byte;
        end
    end

    // ---------------------------------------------
    // Sequencer
    // ---------------------------------------------
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= ST_RX;
            rx_cnt_reg <= 3'h0;
            ovf_reg <= 1'b0;
            cmd_reg <= 8'h00;
            fam_reg <= 8'h00;
            par_reg <= 8'h00;
            tx_idx_reg <= 4'h0;
            answered_o <= 1'b0;
            wake_seen_o <= 1'b0;
        end else begin
            answered_o <= 1'b0;
            case (state_reg)
                ST_RX: begin
                    if (rx_end_i) begin
                        rx_cnt_reg <= 3'h0;
                        ovf_reg <= 1'b0;
                        tx_idx_reg <= 4'h0;
                        if (accept) begin
                            state_reg <= ST_TX;
                            wake_seen_o <= is_wake;
                        end
                    end else if (rx_valid_i) begin
                        if (rx_cnt_reg == 3'h0) cmd_reg <= rx_data_i;
                        if (rx_cnt_reg == 3'h1) fam_reg <= rx_data_i;
                        if (rx_cnt_reg == 3'h2) par_reg <= rx_data_i;
                        if (rx_cnt_reg == `CMD_LEN) begin
                            ovf_reg <= 1'b1;
                        end else begin
                            rx_cnt_reg <= rx_cnt_reg + 3'h1;
                        end
                    end
                end
                ST_TX: begin
                    if (tx_fire) begin
                        tx_idx_reg <= tx_idx_reg + 4'h1;
                        if (tx_idx_reg == `ANS_BODY_LEN - 4'h1) begin
                            state_reg <= ST_CRC;
                        end
                    end
                end
                ST_CRC: begin
                    if (tx_fire) begin
                        if (tx_last_o) begin
                            state_reg <= ST_RX;
                            tx_idx_reg <= 4'h0;
                            answered_o <= 1'b1;
                        end else begin
                            tx_idx_reg <= tx_idx_reg + 4'h1;
                        end
                    end
                end
                default: state_reg <= ST_RX;
            endcase
        end
    end
endmodule // typeb_request_wakeup_responder

// ---- bench/typeb_reader_model.sv ----
// Purpose: Reader model sending request frames and draining answers
// Assumes: One byte per cycle, frame end pulse after the check bytes
// Notes: Guard gap shortened; slow mode stalls every other cycle
`timescale 1ns/1ps
module typeb_reader_model #(parameter GUARD = 8) (
    input wire core_clk_i,
    input wire ans_valid_i,
    input wire [7:0] ans_data_i,
    output reg cmd_valid_o = 1'b0,
    output reg [7:0] cmd_data_o = 8'h00,
    output reg cmd_end_o = 1'b0,
    output reg ans_ready_o = 1'b1
);
    reg [7:0] ans [0:15];
    reg [7:0] n = 8'h00;
    reg slow = 1'b0;
    function [15:0] crc_upd(input [15:0] c, input [7:0] d);
        integer k;
        begin
            crc_upd = c ^ {8'h00, d};
            for (k = 0; k < 8; k = k + 1)
                crc_upd = (crc_upd >> 1) ^ (crc_upd[0] ? 16'h8408 : 16'h0000);
        end
    endfunction
    task send(input [7:0] c, f, p, input bad);
        reg [15:0] r;
        reg [39:0] fr;
        integer k;
        begin
            repeat (GUARD) @(posedge core_clk_i);
            r = ~crc_upd(crc_upd(crc_upd(16'h6363, c), f), p);
            fr = {c, f, p, r[7:0] ^ {7'h00, bad}, r[15:8]};
            n = 8'h00;
            for (k = 0; k < 5; k = k + 1) begin
                @(posedge core_clk_i);
                cmd_valid_o <= 1'b1;
                cmd_data_o <= fr[39 - 8 * k -: 8];
            end
            @(posedge core_clk_i);
            cmd_valid_o <= 1'b0;
            cmd_data_o <= ~cmd_data_o;
            cmd_end_o <= 1'b1;
            @(posedge core_clk_i);
            cmd_end_o <= 1'b0;
        end
    endtask
    // Sink can stall to exercise the hold of each answer byte
    always @(posedge core_clk_i) begin
        ans_ready_o <= slow ? ~ans_ready_o : 1'b1;
        if (ans_valid_i && ans_ready_o) begin
            ans[n[3:0]] <= ans_data_i;
            n <= n + 8'h01;
        end
    end
endmodule // typeb_reader_model

// ---- bench/typeb_rsp_asserts.sv ----
// Purpose: Port checks for the request responder
// Assumes: One clock, async active-low reset
// Notes: Byte index counts answer bytes taken
`timescale 1ns/1ps
module typeb_rsp_asserts (
    input logic core_clk_i,
    input logic arst_n_i,
    input logic rx_end_i,
    input logic [31:0] identifier_i,
    input logic fast_rate_select_i,
    input logic typeb_rate_select_i,
    input logic [3:0] wait_int_i,
    input logic tx_ready_i,
    input logic tx_valid_o,
    input logic [7:0] tx_data_o,
    input logic tx_last_o,
    input logic answered_o
);
    reg [3:0] cnt;
    wire [1:0] sel = cnt[1:0] - 2'd1;
    wire [7:0] rate = (!fast_rate_select_i && typeb_rate_select_i) ? 8'hB3 : 8'h80;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    always @(posedge core_clk_i or negedge arst_n_i)
        if (!arst_n_i)
            cnt <= 4'h0;
        else if (!tx_valid_o)
            cnt <= 4'h0;
        else if (tx_ready_i)
            cnt <= cnt + 4'h1;
    sequence s_last_taken;
        tx_valid_o && tx_ready_i && tx_last_o;
    endsequence
    property p_code; tx_valid_o && cnt == 4'h0 |-> tx_data_o == 8'h50; endproperty
    a_code: assert property (p_code) else $error("code byte");
    property p_ident; tx_valid_o && cnt >= 4'h1 && cnt <= 4'h4
        |-> tx_data_o == identifier_i[{sel, 3'b000} +: 8]; endproperty
    a_ident: assert property (p_ident) else $error("identifier byte");
    property p_zero; tx_valid_o && cnt >= 4'h5 && cnt <= 4'h8 |-> tx_data_o == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("data byte");
    property p_rate; tx_valid_o && cnt == 4'h9 |-> tx_data_o == rate; endproperty
    a_rate: assert property (p_rate) else $error("rate byte");
    property p_size; tx_valid_o && cnt == 4'hA |-> tx_data_o == 8'h81; endproperty
    a_size: assert property (p_size) else $error("size byte");
    property p_wait; tx_valid_o && cnt == 4'hB |-> tx_data_o == {wait_int_i, 4'h0}; endproperty
    a_wait: assert property (p_wait) else $error("wait byte");
    property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o); endproperty
    a_hold: assert property (p_hold) else $error("byte not held");
    property p_done; s_last_taken |-> cnt == 4'hD ##1 answered_o && !tx_valid_o
        ##1 !answered_o; endproperty
    a_done: assert property (p_done) else $error("frame end");
    property p_prompt; $rose(tx_valid_o) |-> $past(rx_end_i); endproperty
    a_prompt: assert property (p_prompt) else $error("late answer");
endmodule // typeb_rsp_asserts

// ---- bench/typeb_request_wakeup_responder_bench.sv ----
// Purpose: Self-checking bench for the request responder
// Assumes: Reader model drives frames and drains answers
// Notes: Expected frames built here, check bytes included
`timescale 1ns/1ps
module typeb_request_wakeup_responder_bench;
    reg core_clk_i = 1'b0;
    reg arst_n_i = 1'b0;
    reg halted = 1'b0, active = 1'b0, fast = 1'b0, typeb = 1'b1;
    reg [7:0] family = 8'h13;
    reg [3:0] wait_int = 4'h7;
    reg [31:0] ident = 32'hA1B2_C3D4;
    wire rx_valid, rx_end, tx_ready, tx_valid, tx_last, answered, wake_seen, busy;
    wire [7:0] rx_data, tx_data;
    reg [95:0] body;
    reg [15:0] c;
    reg [7:0] got;
    reg [7:0] code = 8'h05;
    integer mismatches = 0, n_tests = 0, k;
    initial forever #25 core_clk_i = ~core_clk_i;
    typeb_request_wakeup_responder i_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_end_i(rx_end), .halted_i(halted),
        .active_i(active), .family_setting_i(family), .identifier_i(ident),
        .fast_rate_select_i(fast), .typeb_rate_select_i(typeb), .wait_int_i(wait_int),
        .tx_ready_i(tx_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
        .tx_last_o(tx_last), .answered_o(answered), .wake_seen_o(wake_seen), .busy_o(busy));
    typeb_reader_model i_rdr (.core_clk_i(core_clk_i), .ans_valid_i(tx_valid),
        .ans_data_i(tx_data), .cmd_valid_o(rx_valid), .cmd_data_o(rx_data),
        .cmd_end_o(rx_end), .ans_ready_o(tx_ready));
    task chk(input [7:0] g, e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("BAD t=%0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task run(input [7:0] fam, par, input bad, yes);
        begin
            i_rdr.send(code, fam, par, bad);
            @(negedge core_clk_i);
            chk({7'h00, busy}, {7'h00, yes});
            got = 8'h00;
            for (k = 0; k < 60 && got == 8'h00; k = k + 1) begin
                @(negedge core_clk_i);
                got = {7'h00, answered === 1'b1};
            end
            chk(got, {7'h00, yes});
            if (yes) begin
                body = {8'h50, ident[7:0], ident[15:8], ident[23:16], ident[31:24], 32'h0000_0000,
                    (!fast && typeb) ? 8'hB3 : 8'h80, 8'h81, wait_int, 4'h0};
                c = 16'h6363;
                for (k = 0; k < 12; k = k + 1) begin
                    chk(i_rdr.ans[k], body[95 - 8 * k -: 8]);
                    c = i_rdr.crc_upd(c, body[95 - 8 * k -: 8]);
                end
                chk(i_rdr.ans[12], ~c[7:0]);
                chk(i_rdr.ans[13], ~c[15:8]);
                chk(i_rdr.n, 8'h0E);
                chk({7'h00, wake_seen}, {7'h00, par[3]});
            end
            if (!yes) chk(i_rdr.n, 8'h00);
        end
    endtask
    task final_report;
        begin
            $display("Compares %0d, mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    initial begin
        #200000;
        mismatches = mismatches + 1;
        final_report;
    end
    initial begin
        repeat (5) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        run(8'h00, 8'h00, 1'b0, 1'b1);
        run(8'h03, 8'hE7, 1'b0, 1'b1);
        run(8'h04, 8'h00, 1'b0, 1'b0);
        run(8'h10, 8'h00, 1'b0, 1'b1);
        run(8'h20, 8'h00, 1'b0, 1'b0);
        run(8'h13, 8'h04, 1'b0, 1'b1);
        run(8'h31, 8'h00, 1'b0, 1'b0);
        run(8'h00, 8'h00, 1'b1, 1'b0);
        run(8'h00, 8'h10, 1'b0, 1'b0);
        code = 8'h1D;
        run(8'h00, 8'h00, 1'b0, 1'b0);
        code = 8'h05;
        @(posedge core_clk_i);
        halted <= 1'b1;
        fast <= 1'b1;
        wait_int <= 4'hA;
        i_rdr.slow <= 1'b1;
        run(8'h00, 8'h00, 1'b0, 1'b0);
        run(8'h00, 8'h08, 1'b0, 1'b1);
        @(posedge core_clk_i);
        halted <= 1'b0;
        active <= 1'b1;
        run(8'h00, 8'h08, 1'b0, 1'b0);
        @(posedge core_clk_i);
        active <= 1'b0;
        fast <= 1'b0;
        typeb <= 1'b0;
        run(8'h00, 8'h08, 1'b0, 1'b1);
        final_report;
    end
endmodule // typeb_request_wakeup_responder_bench
bind typeb_request_wakeup_responder typeb_rsp_asserts i_chk (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .rx_end_i(rx_end_i),
    .identifier_i(identifier_i),
    .fast_rate_select_i(fast_rate_select_i),
    .typeb_rate_select_i(typeb_rate_select_i),
    .wait_int_i(wait_int_i),
    .tx_ready_i(tx_ready_i),
    .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o),
    .tx_last_o(tx_last_o),
    .answered_o(answered_o)
);
